/* core/sacc_top.sv */
// SAR converter control: APB registers, run control, result and flag.
// Assumes an APB master on pclk and an analog front end that follows
// sample_switch, tap_code and channel_sel and returns cmp_hi.
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
// Behaviours
module sacc_top #(
    parameter bit RESTART_ON_WRITE = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sacc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic standby,
    input wire logic cmp_hi,
    output logic sample_switch,
    output logic [sacc_pkg::RES_W-1:0] tap_code,
    output logic [sacc_pkg::CHAN_W-1:0] channel_sel,
    output logic reference_power_en,
    output logic conversion_end_irq
);
    typedef struct packed {
        logic conversion_run_bit;
        logic reference_power_bit;
        sacc_pkg::sacc_speed_t speed_select_field;
        logic [sacc_pkg::CHAN_W-1:0] channel_select_reg;
        logic [sacc_pkg::THR_W-1:0] threshold_reg;
        logic compare_enable_bit;
        logic compare_direction_bit;
        logic [sacc_pkg::RES_W-1:0] conversion_result_reg;
        logic conversion_irq_flag;
        logic pend_valid;
        logic [sacc_pkg::RES_W-1:0] pend_res;
        logic irq;
        logic en_prev;
        logic restart;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sacc_top_state_t;

    sacc_top_state_t q, d;
    sacc_pkg::sacc_sar_ctl_t ctl;
    sacc_pkg::sacc_sar_stat_t stat;

    logic acc, fin, wr, mapped;
    logic wr_mode, wr_chan, wr_thr, wr_cmp, wr_irq;
    logic en, conflict, rd_res, cmp_ok, irq_ok, set_flag, sd;
    logic [sacc_pkg::THR_W-1:0] result_upper_byte;
    logic [31:0] rd_word;

    always_comb
    begin
        acc = psel && penable;
        fin = acc && q.pready;
        wr = fin && pwrite;
        mapped = (paddr == sacc_pkg::MODE_OFS) || (paddr == sacc_pkg::CHAN_OFS)
            || (paddr == sacc_pkg::RESULT_OFS)
            || (paddr == sacc_pkg::THRESH_OFS)
            || (paddr == sacc_pkg::CMP_OFS) || (paddr == sacc_pkg::IRQ_OFS)
            || (paddr == sacc_pkg::STAT_OFS);
        wr_mode = wr && (paddr == sacc_pkg::MODE_OFS);
        wr_chan = wr && (paddr == sacc_pkg::CHAN_OFS);
        wr_thr = wr && (paddr == sacc_pkg::THRESH_OFS);
        wr_cmp = wr && (paddr == sacc_pkg::CMP_OFS);
        wr_irq = wr && (paddr == sacc_pkg::IRQ_OFS);
        rd_res = acc && !pwrite && (paddr == sacc_pkg::RESULT_OFS);
        sd = stat.done;

        en = q.conversion_run_bit && !standby
            && sacc_pkg::speed_ok(q.speed_select_field);

        conflict = wr_mode || wr_chan;

        result_upper_byte = stat.result[sacc_pkg::RES_W-1 -: sacc_pkg::THR_W];
        cmp_ok = q.compare_direction_bit ? (result_upper_byte < q.threshold_reg)
            : (result_upper_byte >= q.threshold_reg);
        irq_ok = !q.compare_enable_bit || cmp_ok;
        set_flag = sd && !conflict && irq_ok;

        rd_word = '0;
        unique case (paddr)
            sacc_pkg::MODE_OFS:
            begin
                rd_word[sacc_pkg::MODE_RUN_BIT] = q.conversion_run_bit;
                rd_word[sacc_pkg::MODE_REF_BIT] = q.reference_power_bit;
                rd_word[sacc_pkg::MODE_SPD_LSB +: sacc_pkg::SPD_W] =
                    q.speed_select_field;
            end
            sacc_pkg::CHAN_OFS: rd_word[sacc_pkg::CHAN_W-1:0] = q.channel_select_reg;
            sacc_pkg::RESULT_OFS:
                rd_word[sacc_pkg::RES_W-1:0] = q.conversion_result_reg;
            sacc_pkg::THRESH_OFS: rd_word[sacc_pkg::THR_W-1:0] = q.threshold_reg;
            sacc_pkg::CMP_OFS:
            begin
                rd_word[sacc_pkg::CMP_EN_BIT] = q.compare_enable_bit;
                rd_word[sacc_pkg::CMP_DIR_BIT] = q.compare_direction_bit;
            end
            sacc_pkg::IRQ_OFS: rd_word[sacc_pkg::IRQ_FLAG_BIT] = q.conversion_irq_flag;
            sacc_pkg::STAT_OFS:
                rd_word[3:0] = {q.pend_valid,
                    !sacc_pkg::speed_ok(q.speed_select_field), standby, stat.busy};
            default: rd_word = '0;
        endcase

        d = q;
        // One wait state: data is latched in the first access cycle.
        d.pready = acc && !q.pready;
        d.prdata = (acc && !q.pready) ? rd_word : '0;
        d.pslverr = acc && !q.pready && !mapped;

        if (wr_mode)
        begin
            d.conversion_run_bit = pwdata[sacc_pkg::MODE_RUN_BIT];
            d.reference_power_bit = pwdata[sacc_pkg::MODE_REF_BIT];
            d.speed_select_field = pwdata[sacc_pkg::MODE_SPD_LSB +: sacc_pkg::SPD_W];
        end
        if (wr_chan)
        begin
            d.channel_select_reg = pwdata[sacc_pkg::CHAN_W-1:0];
        end
        if (wr_thr)
        begin
            d.threshold_reg = pwdata[sacc_pkg::THR_W-1:0];
        end
        if (wr_cmp)
        begin
            d.compare_enable_bit = pwdata[sacc_pkg::CMP_EN_BIT];
            d.compare_direction_bit = pwdata[sacc_pkg::CMP_DIR_BIT];
        end

        // control write restarts a running conversion
        d.restart = RESTART_ON_WRITE && q.conversion_run_bit
            && (wr_mode || wr_chan || wr_thr || wr_cmp);
        d.en_prev = en;
        ctl.start = en && (!q.en_prev || q.restart);
        ctl.abort = !en;
        ctl.speed = q.speed_select_field;

        // deferred store after a result read
        if (q.pend_valid && !rd_res)
        begin
            d.conversion_result_reg = q.pend_res;
            d.pend_valid = 1'b0;
        end
        // a coinciding mode or channel write keeps the old result
        if (sd && !conflict)
        begin
            if (rd_res)
            begin
                d.pend_valid = 1'b1;
                d.pend_res = stat.result;
            end
            else
            begin
                d.conversion_result_reg = stat.result;
            end
        end

        // only the flag register clears the flag
        if (wr_irq)
        begin
            d.conversion_irq_flag = pwdata[sacc_pkg::IRQ_FLAG_BIT];
        end
        // set wins over a same-cycle clear
        // an end in the cycle of a mode or channel write does not set the flag
        if (set_flag)
        begin
            d.conversion_irq_flag = 1'b1;
        end
        d.irq = set_flag;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    sacc_sar #(
        .RESTART(RESTART_ON_WRITE)
    ) u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .ctl(ctl),
        .cmp_hi(cmp_hi),
        .stat(stat)
    );

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign sample_switch = stat.sample;
    assign tap_code = stat.tap;
    assign channel_sel = q.channel_select_reg;
    assign reference_power_en = q.reference_power_bit;
    assign conversion_end_irq = q.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_irq_set;
        set_flag |=> (q.conversion_irq_flag && q.irq);
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("flag or interrupt missing after conversion end");

    property p_conflict;
        (sd && conflict) |=> ($stable(q.conversion_result_reg) && !q.irq);
    endproperty
    a_conflict: assert property (p_conflict)
        else $error("conflicting write did not suppress result");

    property p_read_first;
        (sd && rd_res && !conflict) |=> $stable(q.conversion_result_reg);
    endproperty
    a_read_first: assert property (p_read_first)
        else $error("result changed during a result read");

    property p_pend_store;
        (q.pend_valid && !rd_res)
            |=> (q.conversion_result_reg == $past(q.pend_res) && !q.pend_valid);
    endproperty
    a_pend_store: assert property (p_pend_store)
        else $error("deferred result not stored");

    property p_chan_keep;
        (wr_chan && !set_flag) |=> $stable(q.conversion_irq_flag);
    endproperty
    a_chan_keep: assert property (p_chan_keep)
        else $error("channel write changed the flag");

    sequence s_run_cleared;
        wr_mode && !pwdata[sacc_pkg::MODE_RUN_BIT];
    endsequence

    property p_stop;
        s_run_cleared |=> ##1 !stat.busy;
    endproperty
    a_stop: assert property (p_stop)
        else $error("converter still busy after run cleared");

    property p_standby;
        standby |=> !stat.busy;
    endproperty
    a_standby: assert property (p_standby)
        else $error("converter busy in standby");

    property p_gate;
        (sd && !conflict && !irq_ok) |=> (!q.irq && $stable(q.conversion_irq_flag));
    endproperty
    a_gate: assert property (p_gate)
        else $error("interrupt raised although compare failed");

    property p_restart;
        (q.restart && en) |=> (stat.busy && !stat.sample);
    endproperty
    a_restart: assert property (p_restart)
        else $error("control write did not restart conversion");

    property p_auto;
        (sd && en) |-> stat.sample;
    endproperty
    a_auto: assert property (p_auto)
        else $error("no automatic restart after conversion end");

endmodule // sacc_top

/* core/sacc_pkg.sv */
// Shared constants, types and timing tables of the SAR converter control.
// Assumes a 100 MHz main clock; conversion figures are in clock periods.
package sacc_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned RES_W = 10;
    localparam int unsigned CNT_W = 9;
    localparam int unsigned SPD_W = 3;
    localparam int unsigned CHAN_W = 3;
    localparam int unsigned THR_W = 8;

    localparam logic [ADDR_W-1:0] MODE_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CHAN_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] RESULT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] THRESH_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] CMP_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] IRQ_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] STAT_OFS = 8'h18;

    localparam int unsigned MODE_RUN_BIT = 0;
    localparam int unsigned MODE_REF_BIT = 1;
    localparam int unsigned MODE_SPD_LSB = 2;
    localparam int unsigned CMP_EN_BIT = 7;
    localparam int unsigned CMP_DIR_BIT = 6;
    localparam int unsigned IRQ_FLAG_BIT = 0;

    localparam logic [SPD_W-1:0] SPD_RST = 3'h0;
    localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
    localparam logic [THR_W-1:0] THR_RST = 8'h00;
    localparam logic [RES_W-1:0] RES_RST = 10'h000;
    localparam logic [RES_W-1:0] SAR_TOP = 10'h200;
    localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
    localparam logic [CNT_W-1:0] BITS_PER_RESULT = 9'h00A;

    typedef logic [SPD_W-1:0] sacc_speed_t;
    typedef logic [CNT_W-1:0] sacc_cnt_t;

    typedef struct packed {
        logic start;
        logic abort;
        sacc_speed_t speed;
    } sacc_sar_ctl_t;

    typedef struct packed {
        logic busy;
        logic sample;
        logic done;
        logic [RES_W-1:0] result;
        logic [RES_W-1:0] tap;
    } sacc_sar_stat_t;

    function automatic logic speed_ok(input sacc_speed_t s);
        speed_ok = (s != 3'h3) && (s != 3'h7);
    endfunction

    function automatic sacc_cnt_t conv_cycles(input sacc_speed_t s);
        unique case (s)
            3'h0: conv_cycles = 9'h120;
            3'h1: conv_cycles = 9'h0F0;
            3'h2: conv_cycles = 9'h0C0;
            3'h4: conv_cycles = 9'h090;
            3'h5: conv_cycles = 9'h078;
            default: conv_cycles = 9'h060;
        endcase
    endfunction

    function automatic sacc_cnt_t samp_cycles(input sacc_speed_t s);
        unique case (s)
            3'h0: samp_cycles = 9'h028;
            3'h1: samp_cycles = 9'h020;
            3'h2: samp_cycles = 9'h018;
            3'h4: samp_cycles = 9'h014;
            3'h5: samp_cycles = 9'h010;
            default: samp_cycles = 9'h00C;
        endcase
    endfunction

    // Restarting variants have the longer start delay column.
    function automatic sacc_cnt_t delay_cycles(input sacc_speed_t s,
                                               input logic restart);
        unique case (s)
            3'h0: delay_cycles = restart ? 9'h020 : 9'h00B;
            3'h1: delay_cycles = restart ? 9'h01C : 9'h00B;
            3'h2: delay_cycles = restart ? 9'h018 : 9'h00A;
            3'h4: delay_cycles = restart ? 9'h010 : 9'h009;
            3'h5: delay_cycles = restart ? 9'h00E : 9'h009;
            default: delay_cycles = restart ? 9'h00C : 9'h00B;
        endcase
    endfunction

endpackage

/* core/sacc_sar.sv */
// Successive-approximation sequencer: start delay, sampling, ten decisions.
// Assumes an analog comparator result on cmp_hi, valid one cycle after tap.
`timescale 1ns/1ps
module sacc_sar #(
    parameter bit RESTART = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input sacc_pkg::sacc_sar_ctl_t ctl,
    input wire logic cmp_hi,
    output sacc_pkg::sacc_sar_stat_t stat
);
    typedef enum logic [1:0] {SACC_IDLE, SACC_DELAY, SACC_SAMPLE, SACC_CONV}
        sacc_phase_t;

    typedef struct packed {
        sacc_phase_t phase;
        sacc_pkg::sacc_cnt_t cnt;
        sacc_pkg::sacc_cnt_t step_cnt;
        logic [3:0] bit_idx;
        logic bits_left;
        logic [sacc_pkg::RES_W-1:0] sar;
        sacc_pkg::sacc_speed_t code;
        sacc_pkg::sacc_sar_stat_t st;
    } sacc_sar_state_t;

    sacc_sar_state_t q, d;
    sacc_pkg::sacc_cnt_t step;
    logic [sacc_pkg::RES_W-1:0] trial;

    always_comb
    begin
        d = q;
        d.st.done = 1'b0;
        step = 9'((sacc_pkg::conv_cycles(q.code) - sacc_pkg::samp_cycles(q.code))
            / sacc_pkg::BITS_PER_RESULT);
        trial = q.sar;
        unique case (q.phase)
            SACC_IDLE: ;
            SACC_DELAY:
            begin
                d.cnt = q.cnt + sacc_pkg::CNT_ONE;
                if (q.cnt == sacc_pkg::delay_cycles(q.code, RESTART) - 9'h001)
                begin
                    d.phase = SACC_SAMPLE;
                    d.cnt = '0;
                end
            end
            SACC_SAMPLE:
            begin
                d.cnt = q.cnt + sacc_pkg::CNT_ONE;
                if (q.cnt == sacc_pkg::samp_cycles(q.code) - 9'h001)
                begin
                    d.phase = SACC_CONV;
                    d.sar = sacc_pkg::SAR_TOP;
                    d.bit_idx = 4'h9;
                    d.bits_left = 1'b1;
                    d.step_cnt = '0;
                end
            end
            SACC_CONV:
            begin
                d.cnt = q.cnt + sacc_pkg::CNT_ONE;
                if (q.bits_left)
                begin
                    d.step_cnt = q.step_cnt + sacc_pkg::CNT_ONE;
                    if (q.step_cnt == step - 9'h001)
                    begin
                        d.step_cnt = '0;
                        if (!cmp_hi)
                        begin
                            trial[q.bit_idx] = 1'b0;
                        end
                        if (q.bit_idx != 4'h0)
                        begin
                            trial[q.bit_idx - 4'h1] = 1'b1;
                            d.bit_idx = q.bit_idx - 4'h1;
                        end
                        else
                        begin
                            d.bits_left = 1'b0;
                        end
                        d.sar = trial;
                    end
                end
                if (q.cnt == sacc_pkg::conv_cycles(q.code) - 9'h001)
                begin
                    d.st.done = 1'b1;
                    d.st.result = trial;
                    d.phase = SACC_SAMPLE;
                    d.cnt = '0;
                end
            end
        endcase
        // An aborted or restarted conversion reports no result.
        if (ctl.start)
        begin
            d.phase = SACC_DELAY;
            d.cnt = '0;
            d.code = ctl.speed;
            d.st.done = 1'b0;
        end
        else if (ctl.abort)
        begin
            d.phase = SACC_IDLE;
            d.st.done = 1'b0;
        end
        d.st.busy = (d.phase != SACC_IDLE);
        d.st.sample = (d.phase == SACC_SAMPLE);
        d.st.tap = d.sar;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '{phase: SACC_IDLE, default: '0};
        end
        else
        begin
            q <= d;
        end
    end

    assign stat = q.st;

    // Helper counters read only by the checks below.
    sacc_pkg::sacc_cnt_t hlp_samp_q, hlp_dly_q;
    logic [9:0] hlp_tot_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hlp_samp_q <= '0;
            hlp_dly_q <= '0;
            hlp_tot_q <= '0;
        end
        else
        begin
            hlp_samp_q <= q.st.sample ? hlp_samp_q + 9'h001 : '0;
            hlp_dly_q <= (q.phase == SACC_DELAY) ? hlp_dly_q + 9'h001 : '0;
            hlp_tot_q <= (q.st.sample && q.cnt == '0) ? 10'h001
                : hlp_tot_q + 10'h001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_enter_delay;
        ctl.start ##1 (q.phase == SACC_DELAY && q.cnt == '0);
    endsequence

    property p_delay_len;
        ($rose(q.st.sample) && $past(q.phase) == SACC_DELAY)
            |-> hlp_dly_q == sacc_pkg::delay_cycles(q.code, RESTART);
    endproperty
    a_delay_len: assert property (p_delay_len)
        else $error("start delay length wrong");

    property p_start_delay;
        ctl.start |-> s_enter_delay;
    endproperty
    a_start_delay: assert property (p_start_delay)
        else $error("start did not enter the delay phase");

    property p_samp_len;
        ($fell(q.st.sample) && q.phase == SACC_CONV)
            |-> hlp_samp_q == sacc_pkg::samp_cycles(q.code);
    endproperty
    a_samp_len: assert property (p_samp_len)
        else $error("sampling time wrong");

    property p_conv_len;
        q.st.done |-> hlp_tot_q == 10'(sacc_pkg::conv_cycles(q.code));
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion time wrong");

endmodule // sacc_sar

/* test/sacc_afe_model.sv */
// Behavioural analog front end: eight input levels and one comparator.
// Assumes the converter reads cmp_hi at least one cycle after it sets tap_code.
`timescale 1ns/1ps
module sacc_afe_model (
    input wire logic pclk,
    input wire logic [sacc_pkg::RES_W-1:0] tap_code,
    input wire logic [sacc_pkg::CHAN_W-1:0] channel_sel,
    output logic cmp_hi
);
    logic [sacc_pkg::RES_W-1:0] level [8];
    // Registered so a decision never sees a tap from the same cycle.
    always @(posedge pclk)
        cmp_hi <= (level[channel_sel] >= tap_code);
endmodule // sacc_afe_model

/* test/sar_adc_conversion_control_test.sv */
// Self-checking bench of the converter control over APB.
// Assumes the front end model sacc_afe_model on the analog side.
`timescale 1ns/1ps
`define CHK(a, b) \
begin check_count++; if ((a) !== (b)) begin num_errors++; \
$display("MISMATCH t=%0t line %0d", $time, `__LINE__); end end
module sar_adc_conversion_control_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, standby = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, sample_switch, cmp_hi, ref_en, irq, err;
    logic [9:0] tap_code, vin;
    logic [2:0] channel_sel, ch;
    int num_errors = 0, check_count = 0, n, w;
    localparam int T_TAB[8] = '{288, 240, 192, 0, 144, 120, 96, 0};
    localparam int S_TAB[8] = '{40, 32, 24, 0, 20, 16, 12, 0};
    localparam int D_TAB[8] = '{32, 28, 24, 0, 16, 14, 12, 0};
    sacc_top sacc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .standby(standby), .cmp_hi(cmp_hi),
        .sample_switch(sample_switch), .tap_code(tap_code),
        .channel_sel(channel_sel), .reference_power_en(ref_en),
        .conversion_end_irq(irq));
    sacc_afe_model sacc_afe_model_i (.pclk(pclk), .tap_code(tap_code),
        .channel_sel(channel_sel), .cmp_hi(cmp_hi));
    initial
    begin
        forever #5 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Leaves n at lim when no pulse arrived in time.
    task automatic wait_irq(input int lim);
        n = 0;
        @(posedge pclk);
        while (irq !== 1'b1 && n < lim)
        begin
            n++;
            @(posedge pclk);
        end
    endtask
    task automatic watch_sample();
        w = 0;
        n = 0;
        @(posedge pclk);
        while (sample_switch !== 1'b1 && w < 200)
        begin
            w++;
            @(posedge pclk);
        end
        while (sample_switch === 1'b1 && n < 200)
        begin
            n++;
            @(posedge pclk);
        end
    endtask
    initial
    begin
        #500000;
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        for (int i = 0; i < 8; i++)
            sacc_afe_model_i.level[i] = 10'h000;
        void'($urandom(32'hD191));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // main clock keeps running for every result read
        // bench never reads the shared port pins
        // only the restarting variant is built here
        apb(1'b0, sacc_pkg::RESULT_OFS, 32'h0);
        `CHK(rd, 32'h0)
        apb(1'b0, 8'h40, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, sacc_pkg::MODE_OFS, 32'h2);
        repeat (1700) @(posedge pclk);
        `CHK(ref_en, 1'b1)
        for (int c = 0; c < 8; c++)
        begin
            ch = 3'($urandom());
            vin = 10'($urandom());
            sacc_afe_model_i.level[ch] = vin;
            apb(1'b1, sacc_pkg::CHAN_OFS, {29'h0, ch});
            apb(1'b1, sacc_pkg::MODE_OFS, 32'(c * 4 + 3));
            `CHK(channel_sel, ch)
            if (T_TAB[c] == 0)
            begin
                wait_irq(300);
                `CHK(n, 300)
                apb(1'b0, sacc_pkg::STAT_OFS, 32'h0);
                `CHK(rd[2], 1'b1)
            end
            else
            begin
                watch_sample();
                `CHK(w >= D_TAB[c] - 1 && w <= D_TAB[c] + 1, 1'b1)
                `CHK(n, S_TAB[c])
                // first result dropped, second one checked
                wait_irq(400);
                wait_irq(400);
                `CHK(n + 1 >= T_TAB[c] && n <= T_TAB[c], 1'b1)
                apb(1'b0, sacc_pkg::RESULT_OFS, 32'h0);
                `CHK(rd, {22'h0, vin})
                apb(1'b1, sacc_pkg::CHAN_OFS, {29'h0, ~ch});
                apb(1'b0, sacc_pkg::IRQ_OFS, 32'h0);
                `CHK(rd[0], 1'b1)
            end
            // flag cleared before the next start
            apb(1'b1, sacc_pkg::MODE_OFS, 32'h2);
            apb(1'b1, sacc_pkg::IRQ_OFS, 32'h0);
            apb(1'b0, sacc_pkg::IRQ_OFS, 32'h0);
            `CHK(rd[0], 1'b0)
        end
        vin = 10'($urandom()) & 10'h1FF;
        sacc_afe_model_i.level[0] = vin;
        apb(1'b1, sacc_pkg::CHAN_OFS, 32'h0);
        apb(1'b1, sacc_pkg::THRESH_OFS, {24'h0, vin[9:2] + 8'h01});
        apb(1'b1, sacc_pkg::CMP_OFS, 32'h80);
        apb(1'b1, sacc_pkg::MODE_OFS, 32'h1B);
        wait_irq(300);
        `CHK(n, 300)
        apb(1'b0, sacc_pkg::RESULT_OFS, 32'h0);
        `CHK(rd, {22'h0, vin})
        apb(1'b1, sacc_pkg::CMP_OFS, 32'hC0);
        wait_irq(300);
        `CHK(n < 300, 1'b1)
        apb(1'b1, sacc_pkg::CMP_OFS, 32'h00);
        @(posedge pclk);
        standby <= 1'b1;
        wait_irq(300);
        `CHK(n, 300)
        standby <= 1'b0;
        wait_irq(300);
        `CHK(n < 300, 1'b1)
        repeat (40) @(posedge pclk);
        apb(1'b1, sacc_pkg::THRESH_OFS, 32'h0);
        wait_irq(300);
        `CHK(n + 4 >= T_TAB[6] + D_TAB[6] && n < 120, 1'b1)
        watch_sample();
        apb(1'b1, sacc_pkg::MODE_OFS, 32'h2);
        wait_irq(300);
        `CHK(n, 300)
        `CHK(sample_switch, 1'b0)
        tally_and_finish();
    end
endmodule // sar_adc_conversion_control_test
